//--- gplut_pkg.sv
// Package with the constants and types of the GPIO lookup table logic.
//
// Functional notes
// - Upper 2-to-1: line 6 from table bits 7..4.
// - Lower 2-to-1: line 2 from table bits 3..0.
// - Upper 3-to-1: line 7 indexed by lines 6..4.
// - Lower 3-to-1: line 3 indexed by lines 2..0.
// - Table acts only in its matching decode mode.
// - All table bytes reset to zero.
// - Two-bit mode: plain, 2-to-1, 3-to-1, 3-to-2.
package gplut_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int        GPLUT_ADDR_W      = 8;     // Register address width.
  localparam int        GPLUT_DATA_W      = 8;     // Register data width.
  localparam int        GPLUT_IO_W        = 8;     // Number of I/O lines.
  localparam logic [7:0] GPLUT_OFS_TABLE_A = 8'h11; // 2-to-1 tables.
  localparam logic [7:0] GPLUT_OFS_TABLE_B = 8'h12; // Upper 3-to-1 table.
  localparam logic [7:0] GPLUT_OFS_TABLE_C = 8'h13; // Lower 3-to-1 table.
  localparam logic [7:0] GPLUT_TABLE_RST   = 8'h00; // Table reset value.
  localparam logic [7:0] GPLUT_UNMAPPED_RD = 8'h00; // Unmapped read data.

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int GPLUT_A_UP_LSB   = 4;  // Upper 2-to-1 half of table a.
  localparam int GPLUT_A_LO_LSB   = 0;  // Lower 2-to-1 half of table a.
  localparam int GPLUT_UP21_OUT   = 6;  // Line driven by upper 2-to-1.
  localparam int GPLUT_LO21_OUT   = 2;  // Line driven by lower 2-to-1.
  localparam int GPLUT_UP31_OUT   = 7;  // Line driven by upper 3-to-1.
  localparam int GPLUT_LO31_OUT   = 3;  // Line driven by lower 3-to-1.
  localparam int GPLUT_UP_SEL_LSB = 4;  // Lowest select line, upper half.
  localparam int GPLUT_LO_SEL_LSB = 0;  // Lowest select line, lower half.

  // ==========================================================================
  // Types
  // ==========================================================================
  // Decode mode of one nibble.
  typedef enum logic [1:0] {
    GPLUT_MODE_PLAIN = 2'b00,  // Normal GPIO, no lookup.
    GPLUT_MODE_2TO1  = 2'b01,  // Two lines select one table bit.
    GPLUT_MODE_3TO1  = 2'b10,  // Three lines select one table bit.
    GPLUT_MODE_3TO2  = 2'b11   // Three to two decode, not served here.
  } gplut_mode_t;

  // Register access request from the device's serial register interface.
  typedef struct packed {
    logic                    wr;     // One-cycle write strobe.
    logic                    rd;     // One-cycle read strobe.
    logic [GPLUT_ADDR_W-1:0] addr;   // Register address.
    logic [GPLUT_DATA_W-1:0] wdata;  // Write data.
  } gplut_req_t;

  // The three lookup table bytes.
  typedef struct packed {
    logic [7:0] a;  // lookup_table_a.
    logic [7:0] b;  // lookup_table_b.
    logic [7:0] c;  // lookup_table_c.
  } gplut_tables_t;

  // Whole state of the lookup logic.
  typedef struct packed {
    gplut_tables_t           tbl;    // Table registers.
    logic [GPLUT_DATA_W-1:0] rdata;  // Registered read data.
    logic                    rvalid; // Read data valid pulse.
  } gplut_state_t;

endpackage : gplut_pkg

//--- gplut_select.sv
// Table bit selector: picks one bit of a table slice by a line pattern.
`timescale 1ns/1ps
module gplut_select
  import gplut_pkg::*;
#(
  parameter int SEL_W = 2  // Number of selecting lines.
) (
  input  wire logic [(1<<SEL_W)-1:0] table_bits,
  input  wire logic [SEL_W-1:0]      sel,
  output logic                       bit_out
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  // Only two or three selecting lines exist in this block.
  if (SEL_W < 2 || SEL_W > 3) begin : g_bad_sel
    $error("gplut_select: SEL_W must be 2 or 3.");
  end

  // ==========================================================================
  // Selection
  // ==========================================================================
  // The all-ones pattern picks the top bit, all-zeros the bottom bit.
  always_comb begin
    bit_out = table_bits[sel];
  end

endmodule // gplut_select

//--- gplut_lookup_logic.sv
// Lookup table logic that drives I/O lines from neighbouring line levels.
`timescale 1ns/1ps
module gplut_lookup_logic
  import gplut_pkg::*;
#(
  parameter int IO_W = GPLUT_IO_W  // Number of I/O lines served.
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire gplut_req_t        req,
  output logic [GPLUT_DATA_W-1:0] rdata,
  output logic                   rvalid,
  input  wire gplut_mode_t       upper_decode_mode,
  input  wire gplut_mode_t       lower_decode_mode,
  input  wire logic [IO_W-1:0]   io_in,
  output logic [IO_W-1:0]        io_out,
  output logic [IO_W-1:0]        io_drive
);

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  // Line positions are fixed for an eight-line port.
  if (IO_W != GPLUT_IO_W) begin : g_bad_io
    $error("gplut_lookup_logic: IO_W must be 8.");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  gplut_state_t s_q;  // Registered state.
  gplut_state_t s_d;  // Next state.

  // Register writes and reads; unmapped writes are ignored.
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = req.rd;
    if (req.wr) begin
      if (req.addr == GPLUT_OFS_TABLE_A) begin
        s_d.tbl.a = req.wdata;  // Next cycle reaches the outputs.
      end else if (req.addr == GPLUT_OFS_TABLE_B) begin
        s_d.tbl.b = req.wdata;
      end else if (req.addr == GPLUT_OFS_TABLE_C) begin
        s_d.tbl.c = req.wdata;
      end
    end
    if (req.rd) begin
      if (req.addr == GPLUT_OFS_TABLE_A) begin
        s_d.rdata = s_q.tbl.a;
      end else if (req.addr == GPLUT_OFS_TABLE_B) begin
        s_d.rdata = s_q.tbl.b;
      end else if (req.addr == GPLUT_OFS_TABLE_C) begin
        s_d.rdata = s_q.tbl.c;
      end else begin
        s_d.rdata = GPLUT_UNMAPPED_RD;  // Unmapped address reads zero.
      end
    end
  end

  // State register; every table comes out of reset cleared.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.tbl.a  <= GPLUT_TABLE_RST;
      s_q.tbl.b  <= GPLUT_TABLE_RST;
      s_q.tbl.c  <= GPLUT_TABLE_RST;
      s_q.rdata  <= GPLUT_UNMAPPED_RD;
      s_q.rvalid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata  = s_q.rdata;
  assign rvalid = s_q.rvalid;

  // ==========================================================================
  // Table selection
  // ==========================================================================
  logic up21_bit;  // Upper 2-to-1 result.
  logic lo21_bit;  // Lower 2-to-1 result.
  logic up31_bit;  // Upper 3-to-1 result.
  logic lo31_bit;  // Lower 3-to-1 result.

  // Upper 2-to-1: lines 5..4 select among bits 7..4 of table a.
  gplut_select #(.SEL_W(2)) u_up21 (
    .table_bits (s_q.tbl.a[GPLUT_A_UP_LSB +: 4]),
    .sel        (io_in[GPLUT_UP_SEL_LSB +: 2]),
    .bit_out    (up21_bit)
  );

  // Lower 2-to-1: lines 1..0 select among bits 3..0 of table a.
  gplut_select #(.SEL_W(2)) u_lo21 (
    .table_bits (s_q.tbl.a[GPLUT_A_LO_LSB +: 4]),
    .sel        (io_in[GPLUT_LO_SEL_LSB +: 2]),
    .bit_out    (lo21_bit)
  );

  // Upper 3-to-1: lines 6..4 index table b.
  gplut_select #(.SEL_W(3)) u_up31 (
    .table_bits (s_q.tbl.b),
    .sel        (io_in[GPLUT_UP_SEL_LSB +: 3]),
    .bit_out    (up31_bit)
  );

  // Lower 3-to-1: lines 2..0 index table c.
  gplut_select #(.SEL_W(3)) u_lo31 (
    .table_bits (s_q.tbl.c),
    .sel        (io_in[GPLUT_LO_SEL_LSB +: 3]),
    .bit_out    (lo31_bit)
  );

  // ==========================================================================
  // Output steering
  // ==========================================================================
  // A table reaches a line only in its own mode; other lines stay GPIO.
  always_comb begin
    io_out   = '0;
    io_drive = '0;
    case (upper_decode_mode)
      GPLUT_MODE_2TO1: begin
        io_out[GPLUT_UP21_OUT]   = up21_bit;
        io_drive[GPLUT_UP21_OUT] = 1'b1;
      end
      GPLUT_MODE_3TO1: begin
        io_out[GPLUT_UP31_OUT]   = up31_bit;
        io_drive[GPLUT_UP31_OUT] = 1'b1;
      end
      default: begin
        io_out[GPLUT_UP31_OUT] = 1'b0;  // Plain or 3-to-2: no lookup.
      end
    endcase
    case (lower_decode_mode)
      GPLUT_MODE_2TO1: begin
        io_out[GPLUT_LO21_OUT]   = lo21_bit;
        io_drive[GPLUT_LO21_OUT] = 1'b1;
      end
      GPLUT_MODE_3TO1: begin
        io_out[GPLUT_LO31_OUT]   = lo31_bit;
        io_drive[GPLUT_LO31_OUT] = 1'b1;
      end
      default: begin
        io_out[GPLUT_LO31_OUT] = 1'b0;  // Plain or 3-to-2: no lookup.
      end
    endcase
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // A write of any byte to table a.
  sequence s_write_a;
    req.wr && req.addr == GPLUT_OFS_TABLE_A;
  endsequence

  // Lower 2-to-1 selected with steady select lines.
  sequence s_lo21_steady;
    lower_decode_mode == GPLUT_MODE_2TO1 && $stable(io_in[1:0]);
  endsequence

  a_up21_line_six: assert property (@(posedge clk) disable iff (rst)
    upper_decode_mode == GPLUT_MODE_2TO1 |->
      io_drive[6] && io_out[6] == s_q.tbl.a[3'd4 + {1'b0, io_in[5:4]}])
    else $error("Upper 2-to-1 output on line 6 is wrong.");

  a_lo21_line_two: assert property (@(posedge clk) disable iff (rst)
    lower_decode_mode == GPLUT_MODE_2TO1 |->
      io_drive[2] && io_out[2] == s_q.tbl.a[io_in[1:0]])
    else $error("Lower 2-to-1 output on line 2 is wrong.");

  a_up31_line_seven: assert property (@(posedge clk) disable iff (rst)
    upper_decode_mode == GPLUT_MODE_3TO1 |->
      io_drive[7] && io_out[7] == s_q.tbl.b[io_in[6:4]])
    else $error("Upper 3-to-1 output on line 7 is wrong.");

  a_lo31_line_three: assert property (@(posedge clk) disable iff (rst)
    lower_decode_mode == GPLUT_MODE_3TO1 |->
      io_drive[3] && io_out[3] == s_q.tbl.c[io_in[2:0]])
    else $error("Lower 3-to-1 output on line 3 is wrong.");

  a_mode_gates_drive: assert property (@(posedge clk) disable iff (rst)
    io_drive == {upper_decode_mode == GPLUT_MODE_3TO1,
                 upper_decode_mode == GPLUT_MODE_2TO1, 2'b00,
                 lower_decode_mode == GPLUT_MODE_3TO1,
                 lower_decode_mode == GPLUT_MODE_2TO1, 2'b00})
    else $error("A table drives a line outside its mode.");

  a_tables_cleared: assert property (@(posedge clk)
    $past(rst) && !rst |-> s_q.tbl == '0)
    else $error("Tables not zero after reset.");

  a_plain_no_drive: assert property (@(posedge clk) disable iff (rst)
    (upper_decode_mode == GPLUT_MODE_PLAIN ||
     upper_decode_mode == GPLUT_MODE_3TO2) &&
    (lower_decode_mode == GPLUT_MODE_PLAIN ||
     lower_decode_mode == GPLUT_MODE_3TO2) |-> io_drive == '0 && io_out == '0)
    else $error("Lookup drives a line in plain or 3-to-2 mode.");

  // The select lines are steady, so their past and present values agree.
  a_write_reaches_line: assert property (
    @(posedge clk) disable iff (rst)
    s_write_a |=> s_lo21_steady |->
      io_out[2] == $past(req.wdata[io_in[1:0]]))
    else $error("Table write did not reach line 2 next cycle.");

  a_read_returns_a: assert property (@(posedge clk) disable iff (rst)
    req.rd && !req.wr && req.addr == GPLUT_OFS_TABLE_A |=>
      rvalid && rdata == $past(s_q.tbl.a))
    else $error("Read of table a returned wrong data.");

endmodule // gplut_lookup_logic

//--- gplut_host_model.sv
// Host model that issues register accesses to the lookup table logic.
`timescale 1ns/1ps
module gplut_host_model
  import gplut_pkg::*;
(
  input  wire logic clk,
  output gplut_req_t req
);
  // ==========================================================================
  // Register access driver
  // ==========================================================================
  // The port is idle at time zero, so nothing is taken during reset.
  initial begin
    req = '0;
  end

  // Places one request just after a falling edge and holds it for one full
  // cycle. Calls may follow back to back because each call overwrites the
  // request once per falling edge, never twice in one time step.
  task automatic access(input logic w, input logic r,
                        input logic [7:0] a, input logic [7:0] d);
    req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk);
  endtask

  // Releases the strobes and waits one cycle.
  task automatic idle();
    req = '0;
    @(negedge clk);
  endtask
endmodule // gplut_host_model

//--- tb_gplut_lookup_logic.sv
// Self-checking testbench of the GPIO lookup table logic.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_gplut_lookup_logic
  import gplut_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clk;          // Core clock, 250 MHz.
  logic        rst;          // Synchronous reset, active high.
  gplut_req_t  req;          // Register request from the host model.
  logic [7:0]  rdata;        // Read data from the block.
  logic        rvalid;       // Read data valid pulse.
  gplut_mode_t up_mode;      // Upper nibble decode mode.
  gplut_mode_t lo_mode;      // Lower nibble decode mode.
  logic [7:0]  io_in;        // Levels on the I/O lines.
  logic [7:0]  io_out;       // Values the lookup drives.
  logic [7:0]  io_drive;     // Lines owned by the lookup.
  logic [7:0]  ta, tb_b, tc; // Expected table contents.
  int          error_cnt;    // Mismatches seen.
  int          total_checks; // Comparisons made.

  // ==========================================================================
  // Clock, design and host
  // ==========================================================================
  // Free running clock with a 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  gplut_lookup_logic i_dut (
    .clk               (clk),
    .rst               (rst),
    .req               (req),
    .rdata             (rdata),
    .rvalid            (rvalid),
    .upper_decode_mode (up_mode),
    .lower_decode_mode (lo_mode),
    .io_in             (io_in),
    .io_out            (io_out),
    .io_drive          (io_drive)
  );

  gplut_host_model i_host (
    .clk (clk),
    .req (req)
  );

  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reads one address and compares the answer one cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.access(1'b0, 1'b1, a, 8'h00);
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask

  // Walks every mode pair and every line pattern and compares the outputs
  // with a lookup worked out from the expected tables.
  task automatic sweep();
    logic [7:0] eo, ed;
    for (int m = 0; m < 16; m++) begin
      for (int p = 0; p < 256; p++) begin
        @(negedge clk);
        up_mode = gplut_mode_t'(m[3:2]);
        lo_mode = gplut_mode_t'(m[1:0]);
        io_in   = p[7:0];
        eo = 8'h00;
        ed = 8'h00;
        if (m[3:2] == 2'b01) begin
          eo[6] = ta[4 + io_in[5:4]];
          ed[6] = 1'b1;
        end else if (m[3:2] == 2'b10) begin
          eo[7] = tb_b[io_in[6:4]];
          ed[7] = 1'b1;
        end
        if (m[1:0] == 2'b01) begin
          eo[2] = ta[io_in[1:0]];
          ed[2] = 1'b1;
        end else if (m[1:0] == 2'b10) begin
          eo[3] = tc[io_in[2:0]];
          ed[3] = 1'b1;
        end
        #1;
        `CHK("io_out", eo, io_out)
        `CHK("io_drive", ed, io_drive)
      end
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  // Cuts a hang short after a bounded number of cycles.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    total_checks = 0;
    rst = 1'b1;
    up_mode = GPLUT_MODE_PLAIN;
    lo_mode = GPLUT_MODE_PLAIN;
    io_in = 8'h00;
    {ta, tb_b, tc} = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h12, 8'h00);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h10, 8'h00);
    i_host.access(1'b1, 1'b1, 8'h11, 8'hA5);
    `CHK("rdata", 8'h00, rdata)
    i_host.access(1'b1, 1'b0, 8'h12, 8'h96);
    i_host.access(1'b1, 1'b0, 8'h13, 8'h3C);
    i_host.access(1'b1, 1'b0, 8'h14, 8'hFF);
    i_host.idle();
    `CHK("rvalid", 1'b0, rvalid)
    {ta, tb_b, tc} = {8'hA5, 8'h96, 8'h3C};
    rd_chk(8'h11, ta);
    rd_chk(8'h12, tb_b);
    rd_chk(8'h13, tc);
    i_host.idle();
    sweep();
    // A table write reaches line 2 in the cycle after it is taken.
    @(negedge clk);
    up_mode = GPLUT_MODE_PLAIN;
    lo_mode = GPLUT_MODE_2TO1;
    io_in   = 8'h03;
    @(negedge clk);
    `CHK("io_out", 8'h00, io_out)
    i_host.access(1'b1, 1'b0, 8'h11, 8'h5A);
    `CHK("io_out", 8'h04, io_out)
    `CHK("io_drive", 8'h04, io_drive)
    i_host.idle();
    // A second reset in mid-run clears every table again.
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    {ta, tb_b, tc} = '0;
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h13, 8'h00);
    i_host.idle();
    sweep();
    wrap_up();
  end
endmodule // tb_gplut_lookup_logic
